/* File: common/uebc_consts.svh */
// Register offsets, field positions and reset values of the endpoint bank control
`ifndef UEBC_CONSTS_SVH
`define UEBC_CONSTS_SVH

`define UEBC_ADDR_W          12
`define UEBC_EP_STRIDE       12'h020
`define UEBC_OFF_CONFIG      12'h100
`define UEBC_OFF_STATE_CLR   12'h104
`define UEBC_OFF_STATE_SET   12'h105
`define UEBC_OFF_STATE       12'h106
`define UEBC_OFF_IRQ_STATUS  12'h010
`define UEBC_OFF_IRQ_MASK    12'h011

`define UEBC_CFG_IN_HI       6
`define UEBC_CFG_IN_LO       4
`define UEBC_CFG_OUT_HI      2
`define UEBC_CFG_OUT_LO      0
`define UEBC_CFG_WMASK       8'h77
`define UEBC_CFG_RESET       8'h00

`define UEBC_ST_BK1_RDY      7
`define UEBC_ST_BK0_RDY      6
`define UEBC_ST_STALL1       5
`define UEBC_ST_STALL0       4
`define UEBC_ST_CUR_BANK     2
`define UEBC_ST_TGL_IN       1
`define UEBC_ST_TGL_OUT      0
`define UEBC_ST_WMASK        8'hf7
`define UEBC_ST_RESET        8'h00

`define UEBC_IRQ_SETUP       0
`define UEBC_IRQ_STALL       1
`define UEBC_IRQ_BUS_RESET   2
`define UEBC_IRQ_W           3

`endif

/* File: common/uebc_pkg.sv */
// Types shared by the endpoint bank control block
package uebc_pkg;

   typedef enum logic [2:0]
   {
      UEBC_TYPE_OFF   = 3'h0,
      UEBC_TYPE_CTRL  = 3'h1,
      UEBC_TYPE_ISO   = 3'h2,
      UEBC_TYPE_BULK  = 3'h3,
      UEBC_TYPE_INTR  = 3'h4,
      UEBC_TYPE_DUAL  = 3'h5,
      UEBC_TYPE_RSV6  = 3'h6,
      UEBC_TYPE_RSV7  = 3'h7
   } uebc_ep_type_t;

   typedef enum logic [1:0]
   {
      UEBC_HS_ACK   = 2'h0,
      UEBC_HS_NAK   = 2'h1,
      UEBC_HS_STALL = 2'h2,
      UEBC_HS_NONE  = 2'h3
   } uebc_handshake_t;

endpackage

/* File: logic/uebc_type_decode.sv */
// Decodes one endpoint's two type fields into bank roles
`timescale 1ns/1ps

module uebc_type_decode
   import uebc_pkg::*;
(
   input  wire logic [2:0] in_bank_type_in,
   input  wire logic [2:0] out_bank_type_in,
   output logic            bank_one_en_out,
   output logic            bank_zero_en_out,
   output logic            dual_out_out,
   output logic            dual_in_out,
   output logic [2:0]      in_xfer_type_out,
   output logic [2:0]      out_xfer_type_out
);

   function automatic logic type_valid(input logic [2:0] code);
      type_valid = (code != 3'h0) && (code <= 3'h5);
   endfunction

   // Codes six and seven are left to software to avoid; they enable nothing
   always_comb
   begin
      bank_one_en_out   = type_valid(in_bank_type_in);
      bank_zero_en_out  = type_valid(out_bank_type_in);
      dual_out_out      = (in_bank_type_in == UEBC_TYPE_DUAL);
      dual_in_out       = (out_bank_type_in == UEBC_TYPE_DUAL);
      in_xfer_type_out  = dual_out_out ? out_bank_type_in : in_bank_type_in;
      out_xfer_type_out = dual_in_out ? in_bank_type_in : out_bank_type_in;
   end

endmodule

/* File: logic/uebc_sync.sv */
// Three-stage synchroniser with agreement filter for an external level
`timescale 1ns/1ps

module uebc_sync
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic async_in,
   output logic      level_out
);

   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end
      else
      begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         level_out <= 1'b0;
      else if (stage2_reg == stage3_reg)
         level_out <= stage3_reg;
   end

endmodule

/* File: logic/uebc_endpoint_bank_control.sv */
// Endpoint configuration, status and handshake choice for a USB device
//
// Notes on behaviour
// - In type field bits 6:4; zero disables bank 1, one to four pick type.
// - In type five makes bank 1 the second bank of a dual OUT endpoint.
// - Bus reset clears the in type field of every endpoint except zero.
// - Out type field bits 2:0; zero disables bank 0, one to four pick type.
// - Out type five makes bank 0 the second bank of a dual IN endpoint.
// - Bus reset clears the out type field of every endpoint except zero.
// - Bit 3 of configuration and status reads zero; software writes zero.
// - Writing one to the clear register clears that status bit; zero does nothing.
// - Writing one to the set register sets that status bit; zero does nothing.
// - Bank ready one means IN bank filled or OUT bank full.
// - A set stall request makes the bank answer IN and OUT tokens with STALL.
// - A received SETUP clears both stall requests of that endpoint.
// - Current bank bit picks bank zero or one for the next dual-bank transfer.
// - In toggle gives the next IN PID: zero DATA0, one DATA1.
// - Out toggle gives the next OUT PID: zero DATA0, one DATA1.
`timescale 1ns/1ps
`include "uebc_consts.svh"

module uebc_endpoint_bank_control
   import uebc_pkg::*;
#(
   parameter int NUM_EP = 8
)
(
   input  wire logic                      clk_in,
   input  wire logic                      rst_n_in,
   input  wire logic [`UEBC_ADDR_W-1:0]   reg_addr_in,
   input  wire logic [7:0]                reg_wdata_in,
   input  wire logic                      reg_wr_in,
   input  wire logic                      reg_rd_in,
   output logic      [7:0]                reg_rdata_out,
   input  wire logic                      usb_bus_reset_in,
   input  wire logic                      txn_start_in,
   input  wire logic [3:0]                txn_ep_in,
   input  wire logic                      txn_is_in_in,
   input  wire logic                      txn_is_setup_in,
   output uebc_handshake_t                txn_handshake_out,
   output logic                           txn_bank_out,
   output logic                           txn_pid_data1_out,
   output logic      [2:0]                txn_xfer_type_out,
   input  wire logic                      txn_ack_in,
   input  wire logic                      txn_fill_in,
   output logic                           irq_out
);

   localparam int EPW = $clog2(NUM_EP);

   logic [7:0]            config_reg [NUM_EP];
   logic [7:0]            state_reg  [NUM_EP];
   logic [NUM_EP-1:0]     bank_one_en;
   logic [NUM_EP-1:0]     bank_zero_en;
   logic [NUM_EP-1:0]     dual_out;
   logic [NUM_EP-1:0]     dual_in;
   logic [2:0]            in_type    [NUM_EP];
   logic [2:0]            out_type   [NUM_EP];
   logic                  bus_reset_lvl;
   logic                  bus_reset_prev_reg;
   logic                  bus_reset_pulse;
   logic [`UEBC_IRQ_W-1:0] irq_status_reg;
   logic [`UEBC_IRQ_W-1:0] irq_mask_reg;
   logic [`UEBC_IRQ_W-1:0] irq_event;
   logic                  ep_hit;
   logic [EPW-1:0]        ep_sel;
   logic [`UEBC_ADDR_W-1:0] ep_off;
   logic                  txn_ok;
   logic                  txn_bank;
   logic                  txn_stall;
   logic                  txn_ready;
   logic                  is_dual;
   logic                  irq_read;
   logic                  txn_pend_reg;
   logic [EPW-1:0]        txn_ep_reg;
   logic                  txn_dir_reg;
   logic                  txn_bank_reg;

   function automatic logic addr_is(input logic [`UEBC_ADDR_W-1:0] a,
                                    input logic [`UEBC_ADDR_W-1:0] off);
      addr_is = (a == off);
   endfunction

   function automatic logic ep_reg_is(input logic                    hit,
                                      input logic [`UEBC_ADDR_W-1:0] off,
                                      input logic [`UEBC_ADDR_W-1:0] reg_off);
      ep_reg_is = hit && (off[4:0] == reg_off[4:0]);
   endfunction

   // Bus reset arrives from the line state logic in another timing domain
   uebc_sync u_bus_reset_sync
   (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .async_in  (usb_bus_reset_in),
      .level_out (bus_reset_lvl)
   );

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         bus_reset_prev_reg <= 1'b0;
      else
         bus_reset_prev_reg <= bus_reset_lvl;
   end

   assign bus_reset_pulse = bus_reset_lvl && !bus_reset_prev_reg;

   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++)
      begin : g_ep
         uebc_type_decode u_dec
         (
            .in_bank_type_in   (config_reg[g][`UEBC_CFG_IN_HI:`UEBC_CFG_IN_LO]),
            .out_bank_type_in  (config_reg[g][`UEBC_CFG_OUT_HI:`UEBC_CFG_OUT_LO]),
            .bank_one_en_out   (bank_one_en[g]),
            .bank_zero_en_out  (bank_zero_en[g]),
            .dual_out_out      (dual_out[g]),
            .dual_in_out       (dual_in[g]),
            .in_xfer_type_out  (in_type[g]),
            .out_xfer_type_out (out_type[g])
         );
      end
   endgenerate

   // Endpoint register window decode
   always_comb
   begin
      ep_off = reg_addr_in - `UEBC_OFF_CONFIG;
      ep_sel = ep_off[5 +: EPW];
      ep_hit = (reg_addr_in >= `UEBC_OFF_CONFIG)
               && (ep_off[`UEBC_ADDR_W-1:5] < NUM_EP[`UEBC_ADDR_W-6:0]);
   end

   // Configuration registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < NUM_EP; i++)
            config_reg[i] <= `UEBC_CFG_RESET;
      end
      else
      begin
         if (reg_wr_in && ep_reg_is(ep_hit, ep_off, `UEBC_OFF_CONFIG))
            config_reg[ep_sel] <= reg_wdata_in & `UEBC_CFG_WMASK;
         if (bus_reset_pulse)
         begin
            for (int i = 1; i < NUM_EP; i++)
               config_reg[i] <= `UEBC_CFG_RESET;
         end
      end
   end

   // Selected endpoint for the current transaction
   always_comb
   begin
      txn_ok    = (txn_ep_in < NUM_EP);
      is_dual   = txn_ok && (txn_is_in_in ? dual_in[txn_ep_in[EPW-1:0]]
                                          : dual_out[txn_ep_in[EPW-1:0]]);
      txn_bank  = is_dual ? state_reg[txn_ep_in[EPW-1:0]][`UEBC_ST_CUR_BANK]
                          : txn_is_in_in;
      txn_stall = txn_ok && state_reg[txn_ep_in[EPW-1:0]][txn_bank ? `UEBC_ST_STALL1
                                                                    : `UEBC_ST_STALL0];
      txn_ready = txn_ok && state_reg[txn_ep_in[EPW-1:0]][txn_bank ? `UEBC_ST_BK1_RDY
                                                                    : `UEBC_ST_BK0_RDY];
   end

   // Handshake choice, registered one cycle after the token
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         txn_handshake_out <= UEBC_HS_NONE;
         txn_bank_out      <= 1'b0;
         txn_pid_data1_out <= 1'b0;
         txn_xfer_type_out <= 3'h0;
      end
      else if (txn_start_in)
      begin
         txn_bank_out      <= txn_bank;
         txn_pid_data1_out <= txn_ok && state_reg[txn_ep_in[EPW-1:0]][txn_is_in_in
                              ? `UEBC_ST_TGL_IN : `UEBC_ST_TGL_OUT];
         txn_xfer_type_out <= !txn_ok ? 3'h0 : txn_is_in_in ? in_type[txn_ep_in[EPW-1:0]]
                                                           : out_type[txn_ep_in[EPW-1:0]];
         if (!txn_ok || !(txn_bank ? bank_one_en[txn_ep_in[EPW-1:0]]
                                   : bank_zero_en[txn_ep_in[EPW-1:0]]))
            txn_handshake_out <= UEBC_HS_NONE;
         else if (txn_is_setup_in)
            txn_handshake_out <= UEBC_HS_ACK;
         else if (txn_stall)
            txn_handshake_out <= UEBC_HS_STALL;
         else if (txn_is_in_in ? txn_ready : !txn_ready)
            txn_handshake_out <= UEBC_HS_ACK;
         else
            txn_handshake_out <= UEBC_HS_NAK;
      end
   end

   // Transaction context for the completion update
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         txn_pend_reg <= 1'b0;
         txn_ep_reg   <= '0;
         txn_dir_reg  <= 1'b0;
         txn_bank_reg <= 1'b0;
      end
      else
      begin
         if (txn_start_in)
            txn_pend_reg <= txn_ok && !txn_stall;
         else if (txn_ack_in)
            txn_pend_reg <= 1'b0;
         if (txn_start_in)
         begin
            txn_ep_reg   <= txn_ep_in[EPW-1:0];
            txn_dir_reg  <= txn_is_in_in;
            txn_bank_reg <= txn_bank;
         end
      end
   end

   // Status registers; hardware events win over software writes
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < NUM_EP; i++)
            state_reg[i] <= `UEBC_ST_RESET;
      end
      else
      begin
         if (reg_wr_in && ep_reg_is(ep_hit, ep_off, `UEBC_OFF_STATE_CLR))
            state_reg[ep_sel] <= state_reg[ep_sel]
                                 & ~(reg_wdata_in & `UEBC_ST_WMASK);
         if (reg_wr_in && ep_reg_is(ep_hit, ep_off, `UEBC_OFF_STATE_SET))
            state_reg[ep_sel] <= state_reg[ep_sel]
                                 | (reg_wdata_in & `UEBC_ST_WMASK);
         if (txn_pend_reg && txn_ack_in && !txn_start_in)
         begin
            // Ready bit follows the bank; a filled OUT bank becomes ready
            state_reg[txn_ep_reg][txn_bank_reg ? `UEBC_ST_BK1_RDY : `UEBC_ST_BK0_RDY]
               <= !txn_dir_reg && txn_fill_in;
            state_reg[txn_ep_reg][txn_dir_reg ? `UEBC_ST_TGL_IN : `UEBC_ST_TGL_OUT]
               <= !state_reg[txn_ep_reg][txn_dir_reg ? `UEBC_ST_TGL_IN
                                                     : `UEBC_ST_TGL_OUT];
            if (dual_in[txn_ep_reg] || dual_out[txn_ep_reg])
               state_reg[txn_ep_reg][`UEBC_ST_CUR_BANK]
                  <= !state_reg[txn_ep_reg][`UEBC_ST_CUR_BANK];
         end
         if (txn_start_in && txn_is_setup_in && txn_ok)
         begin
            state_reg[txn_ep_in[EPW-1:0]][`UEBC_ST_STALL1] <= 1'b0;
            state_reg[txn_ep_in[EPW-1:0]][`UEBC_ST_STALL0] <= 1'b0;
         end
      end
   end

   // Interrupt events, status and mask
   assign irq_event[`UEBC_IRQ_SETUP]     = txn_start_in && txn_is_setup_in && txn_ok;
   assign irq_event[`UEBC_IRQ_STALL]     = txn_start_in && !txn_is_setup_in && txn_stall;
   assign irq_event[`UEBC_IRQ_BUS_RESET] = bus_reset_pulse;
   assign irq_read = reg_rd_in && addr_is(reg_addr_in, `UEBC_OFF_IRQ_STATUS);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         irq_status_reg <= '0;
      else
         irq_status_reg <= (irq_read ? '0 : irq_status_reg) | irq_event;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         irq_mask_reg <= '0;
      else if (reg_wr_in && addr_is(reg_addr_in, `UEBC_OFF_IRQ_MASK))
         irq_mask_reg <= reg_wdata_in[`UEBC_IRQ_W-1:0];
   end

   assign irq_out = |(irq_status_reg & irq_mask_reg);

   // Read data, one cycle after the strobe
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         reg_rdata_out <= 8'h00;
      else if (!reg_rd_in)
         reg_rdata_out <= 8'h00;
      else if (addr_is(reg_addr_in, `UEBC_OFF_IRQ_STATUS))
         reg_rdata_out <= {{(8-`UEBC_IRQ_W){1'b0}}, irq_status_reg};
      else if (addr_is(reg_addr_in, `UEBC_OFF_IRQ_MASK))
         reg_rdata_out <= {{(8-`UEBC_IRQ_W){1'b0}}, irq_mask_reg};
      else if (ep_reg_is(ep_hit, ep_off, `UEBC_OFF_CONFIG))
         reg_rdata_out <= config_reg[ep_sel] & `UEBC_CFG_WMASK;
      else if (ep_reg_is(ep_hit, ep_off, `UEBC_OFF_STATE))
         reg_rdata_out <= state_reg[ep_sel] & `UEBC_ST_WMASK;
      else
         reg_rdata_out <= 8'h00;
   end

   // Assertions
   stall_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      txn_start_in && txn_ok && !txn_is_setup_in && txn_stall
      && (txn_bank ? bank_one_en[txn_ep_in[EPW-1:0]] : bank_zero_en[txn_ep_in[EPW-1:0]])
      |=> txn_handshake_out == UEBC_HS_STALL)
      else $error("stall request not answered with STALL");

   setup_clears_stall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      txn_start_in && txn_is_setup_in && txn_ok
      |=> !state_reg[$past(txn_ep_in[EPW-1:0])][`UEBC_ST_STALL1]
          && !state_reg[$past(txn_ep_in[EPW-1:0])][`UEBC_ST_STALL0])
      else $error("setup left a stall request set");

   ep0_keeps_cfg_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus_reset_pulse && !(reg_wr_in && ep_hit && ep_sel == '0)
      |=> config_reg[0] == $past(config_reg[0]))
      else $error("bus reset changed endpoint zero configuration");

   bus_reset_cfg_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus_reset_pulse |=> config_reg[NUM_EP-1] == `UEBC_CFG_RESET)
      else $error("bus reset left an endpoint type set");

   reserved_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $past(reg_rd_in) |-> !reg_rdata_out[3] || $past(irq_read))
      else $error("reserved bit read as one");

   clr_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_wr_in && ep_reg_is(ep_hit, ep_off, `UEBC_OFF_STATE_CLR)
      && reg_wdata_in[`UEBC_ST_CUR_BANK] && !txn_pend_reg
      |=> !state_reg[$past(ep_sel)][`UEBC_ST_CUR_BANK])
      else $error("clear write did not clear current bank");

   set_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_wr_in && ep_reg_is(ep_hit, ep_off, `UEBC_OFF_STATE_SET)
      && reg_wdata_in[`UEBC_ST_BK1_RDY] && !txn_pend_reg
      |=> state_reg[$past(ep_sel)][`UEBC_ST_BK1_RDY])
      else $error("set write did not set bank one ready");

   toggle_flip_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      txn_pend_reg && txn_ack_in && !txn_start_in && !reg_wr_in
      |=> state_reg[$past(txn_ep_reg)][$past(txn_dir_reg) ? `UEBC_ST_TGL_IN
          : `UEBC_ST_TGL_OUT] != $past(state_reg[txn_ep_reg][txn_dir_reg
          ? `UEBC_ST_TGL_IN : `UEBC_ST_TGL_OUT]))
      else $error("data toggle did not invert after ack");

endmodule

/* File: verification/uebc_host_model.sv */
// Host-side model that issues tokens and completes transactions
`timescale 1ns/1ps

module uebc_host_model
   import uebc_pkg::*;
(
   input  wire logic            clk_in,
   input  wire uebc_handshake_t hs_in,
   output logic                 start_out,
   output logic [3:0]           ep_out,
   output logic                 is_in_out,
   output logic                 setup_out,
   output logic                 ack_out,
   output logic                 fill_out
);
   initial
   begin
      start_out = 1'b0;
      ep_out    = 4'hf;
      is_in_out = 1'b0;
      setup_out = 1'b0;
      ack_out   = 1'b0;
      fill_out  = 1'b0;
   end

   task automatic token(input logic [3:0] ep, input logic is_in, input logic setup,
                        input logic ack, input logic fill, output uebc_handshake_t hs);
   begin
      @(posedge clk_in);
      start_out <= 1'b1;
      ep_out    <= ep;
      is_in_out <= is_in;
      setup_out <= setup;
      @(posedge clk_in);
      start_out <= 1'b0;
      ep_out    <= ~ep;
      #1 hs = hs_in;
      // Completion only after the device accepted the packet
      if (ack && hs === UEBC_HS_ACK)
      begin
         @(posedge clk_in);
         ack_out  <= 1'b1;
         fill_out <= fill;
         @(posedge clk_in);
         ack_out  <= 1'b0;
         fill_out <= 1'b0;
      end
      @(posedge clk_in);
      #1;
   end
   endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the endpoint bank control block
`timescale 1ns/1ps
`include "uebc_consts.svh"

module tb_top
   import uebc_pkg::*;
;
   localparam logic [11:0] a_cfg = `UEBC_OFF_CONFIG;
   localparam logic [11:0] a_clr = `UEBC_OFF_STATE_CLR;
   localparam logic [11:0] a_set = `UEBC_OFF_STATE_SET;
   localparam logic [11:0] a_st  = `UEBC_OFF_STATE;
   logic            clk, rst_n, wr_s, rd_s, bus_rst, start, is_in, setup, ack, fill;
   logic            bank, pid, irq;
   logic [11:0]     addr;
   logic [7:0]      wdata, rdata;
   logic [3:0]      ep;
   logic [2:0]      xtype;
   uebc_handshake_t hs, hs_w;
   int              err_total = 0;
   int              n_checks = 0;

   uebc_endpoint_bank_control #(.NUM_EP(4)) uebc_endpoint_bank_control_i (
      .clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .usb_bus_reset_in(bus_rst),
      .txn_start_in(start), .txn_ep_in(ep), .txn_is_in_in(is_in), .txn_is_setup_in(setup),
      .txn_handshake_out(hs), .txn_bank_out(bank), .txn_pid_data1_out(pid),
      .txn_xfer_type_out(xtype), .txn_ack_in(ack), .txn_fill_in(fill), .irq_out(irq));

   uebc_host_model uebc_host_model_i (
      .clk_in(clk), .hs_in(hs), .start_out(start), .ep_out(ep), .is_in_out(is_in),
      .setup_out(setup), .ack_out(ack), .fill_out(fill));

   function automatic logic [11:0] ra(input int n, input logic [11:0] off);
      return off + 12'(n) * `UEBC_EP_STRIDE;
   endfunction

   task automatic complete_run();
   begin
      if (err_total == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
   begin
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   end
   endtask

   task automatic chk_txn(input uebc_handshake_t eh, input logic eb, input logic epid,
                          input logic [2:0] et);
   begin
      n_checks++;
      if (hs_w !== eh || ((eh == UEBC_HS_ACK || eh == UEBC_HS_NAK) &&
          {bank, pid, xtype} !== {eb, epid, et}))
      begin
         err_total++;
         $display("[ERR] %0t answer %h %b%b %h expected %h", $time, hs_w, bank, pid, xtype, eh);
      end
   end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
   begin
      @(posedge clk);
      wr_s  <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_s  <= 1'b0;
      #1;
   end
   endtask

   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
   begin
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk8(rdata, exp);
   end
   endtask

   task automatic t_reset();
   begin
      rdc(ra(1, a_cfg), `UEBC_CFG_RESET);
      rdc(ra(1, a_st), `UEBC_ST_RESET);
      wr(12'h0ff, 8'hff);
      rdc(12'h0ff, 8'h00);
      chk8({7'h0, irq}, 8'h00);
   end
   endtask

   task automatic t_types();
   begin
      for (int c = 0; c < 5; c++)
      begin
         wr(ra(1, a_cfg), {1'b0, 3'(c), 1'b0, 3'(c)});
         uebc_host_model_i.token(4'h1, 1'b1, 1'b0, 1'b0, 1'b0, hs_w);
         chk_txn((c == 0) ? UEBC_HS_NONE : UEBC_HS_NAK, 1'b1, 1'b0, 3'(c));
         uebc_host_model_i.token(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, hs_w);
         chk_txn((c == 0) ? UEBC_HS_NONE : UEBC_HS_ACK, 1'b0, 1'b0, 3'(c));
      end
      wr(ra(1, a_cfg), 8'hc4);
      rdc(ra(1, a_cfg), 8'h44);
   end
   endtask

   task automatic t_dual();
   begin
      wr(ra(1, a_cfg), 8'h53);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, hs_w);
      chk_txn(UEBC_HS_ACK, 1'b0, 1'b0, 3'h3);
      wr(ra(1, a_set), 8'h04);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, hs_w);
      chk_txn(UEBC_HS_ACK, 1'b1, 1'b0, 3'h3);
      wr(ra(1, a_cfg), 8'h25);
      wr(ra(1, a_clr), 8'h04);
      uebc_host_model_i.token(4'h1, 1'b1, 1'b0, 1'b0, 1'b0, hs_w);
      chk_txn(UEBC_HS_NAK, 1'b0, 1'b0, 3'h2);
   end
   endtask

   task automatic t_setclr();
   begin
      wr(ra(2, a_set), 8'hf7);
      rdc(ra(2, a_st), 8'hf7);
      wr(ra(2, a_clr), 8'h00);
      rdc(ra(2, a_st), 8'hf7);
      wr(ra(2, a_clr), 8'h35);
      rdc(ra(2, a_st), 8'hc2);
      wr(ra(2, a_set), 8'h00);
      rdc(ra(2, a_st), 8'hc2);
      wr(ra(2, a_clr), 8'hf7);
      rdc(ra(2, a_st), 8'h00);
   end
   endtask

   task automatic t_stall();
   begin
      wr(ra(1, a_cfg), 8'h33);
      wr(ra(1, a_set), 8'h20);
      uebc_host_model_i.token(4'h1, 1'b1, 1'b0, 1'b0, 1'b0, hs_w);
      chk_txn(UEBC_HS_STALL, 1'b1, 1'b0, 3'h3);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, hs_w);
      chk_txn(UEBC_HS_ACK, 1'b0, 1'b0, 3'h3);
      wr(ra(1, a_set), 8'h10);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, hs_w);
      chk_txn(UEBC_HS_STALL, 1'b0, 1'b0, 3'h3);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b1, 1'b0, 1'b0, hs_w);
      chk_txn(UEBC_HS_ACK, 1'b0, 1'b0, 3'h3);
      rdc(ra(1, a_st), 8'h00);
   end
   endtask

   task automatic t_toggle();
   begin
      wr(ra(1, a_set), 8'h80);
      uebc_host_model_i.token(4'h1, 1'b1, 1'b0, 1'b1, 1'b0, hs_w);
      chk_txn(UEBC_HS_ACK, 1'b1, 1'b0, 3'h3);
      rdc(ra(1, a_st), 8'h02);
      uebc_host_model_i.token(4'h1, 1'b1, 1'b0, 1'b1, 1'b0, hs_w);
      chk_txn(UEBC_HS_NAK, 1'b1, 1'b1, 3'h3);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b0, 1'b1, 1'b1, hs_w);
      chk_txn(UEBC_HS_ACK, 1'b0, 1'b0, 3'h3);
      rdc(ra(1, a_st), 8'h43);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b0, 1'b1, 1'b0, hs_w);
      chk_txn(UEBC_HS_NAK, 1'b0, 1'b1, 3'h3);
   end
   endtask

   task automatic t_irq();
   begin
      wr(`UEBC_OFF_IRQ_MASK, 8'h00);
      rdc(`UEBC_OFF_IRQ_STATUS, 8'h03);
      rdc(`UEBC_OFF_IRQ_STATUS, 8'h00);
      uebc_host_model_i.token(4'h1, 1'b0, 1'b1, 1'b0, 1'b0, hs_w);
      chk8({7'h0, irq}, 8'h00);
      wr(`UEBC_OFF_IRQ_MASK, 8'h01);
      #1 chk8({7'h0, irq}, 8'h01);
      rdc(`UEBC_OFF_IRQ_STATUS, 8'h01);
      chk8({7'h0, irq}, 8'h00);
   end
   endtask

   task automatic t_busrst();
   begin
      wr(ra(0, a_cfg), 8'h11);
      wr(ra(1, a_cfg), 8'h33);
      @(posedge clk);
      bus_rst <= 1'b1;
      repeat (8) @(posedge clk);
      bus_rst <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(ra(0, a_cfg), 8'h11);
      rdc(ra(1, a_cfg), 8'h00);
      rdc(`UEBC_OFF_IRQ_STATUS, 8'h04);
   end
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      rst_n   = 1'b0;
      wr_s    = 1'b0;
      rd_s    = 1'b0;
      bus_rst = 1'b0;
      addr    = 12'h000;
      wdata   = 8'h00;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_types();
      t_dual();
      t_setclr();
      t_stall();
      t_toggle();
      t_irq();
      t_busrst();
      complete_run();
   end

   // Whole sequence needs well under a thousand cycles
   initial
   begin
      #40000;
      err_total++;
      complete_run();
   end
endmodule
